// [verilog/acl_pkg.sv]
// package: register map, field layout and resets for the rule indirect path
package acl_pkg;
    // register indices; the bus byte address is four times each
    localparam logic [7:0] table_port_select_off = 8'h6e;
    localparam logic [7:0] byte_offset_off = 8'h6f;
    localparam logic [7:0] byte_data_off = 8'ha0;
    localparam int table_sel_hi = 7;
    localparam int table_sel_lo = 5;
    localparam int port_num_hi = 3;
    localparam int port_num_lo = 0;
    localparam logic [2:0] table_acl = 3'h2;
    localparam logic [3:0] port_first = 4'h1;
    localparam logic [3:0] port_last = 4'h5;
    localparam int num_ports = 5;
    localparam logic [7:0] rule_entry_byte_two = 8'h02;
    localparam logic [7:0] rule_entry_byte_three = 8'h03;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] offset_reset = 8'h00;
    localparam logic [7:0] ip_match_reset = 8'h00;

    typedef struct packed {
        logic [2:0] table_sel;
        logic [3:0] port_num;
        logic [7:0] entry_byte;
    } indirect_sel_t;
endpackage

// [verilog/acl_ip_match_entry.sv]
// one port's layer 3 ip match bytes
`timescale 1ns/10ps
`default_nettype none
module acl_ip_match_entry
    import acl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [7:0] wr_byte,
    input wire logic [7:0] wr_data,
    output logic [15:0] ip_match_value
);
    logic [7:0] hi_reg;
    logic [7:0] mid_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hi_reg <= ip_match_reset;
        end else if (wr_en && wr_byte == rule_entry_byte_two) begin
            hi_reg <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mid_reg <= ip_match_reset;
        end else if (wr_en && wr_byte == rule_entry_byte_three) begin
            mid_reg <= wr_data;
        end
    end

    assign ip_match_value = {hi_reg, mid_reg};
endmodule
`default_nettype wire

// [verilog/acl_rule_indirect_access.sv]
// apb slave giving indirect byte access to per-port rule entries
// Overview of operation
// - a table code of 010 in control bits 7:5 targets the rule table.
// - control bits 3:0 name the port, one to five, being accessed.
// - the offset byte picks which entry byte the data byte shows.
// - the data byte reads the selected entry byte and writes store there.
// - entry byte 2 holds ip bits 31:24, read/write, cleared at reset.
// - entry byte 3 holds ip bits 23:16, read/write, cleared at reset.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module acl_rule_indirect_access
    import acl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [num_ports*16-1:0] ip_match_value
);
    logic [7:0] ctrl_reg;
    logic [7:0] offset_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [num_ports*16-1:0] ip_match_reg;
    logic [num_ports*16-1:0] ip_match_next;
    indirect_sel_t sel;
    logic setup;
    logic access;
    logic wr_data;
    logic sel_ok;
    logic [7:0] entry_rd;
    logic [31:0] rd_next;
    logic err_next;
    logic [29:0] word_idx;
    logic hit_ctrl;
    logic hit_off;
    logic hit_data;
    logic hit_any;

    assign sel.table_sel = ctrl_reg[table_sel_hi:table_sel_lo];
    assign sel.port_num = ctrl_reg[port_num_hi:port_num_lo];
    assign sel.entry_byte = offset_reg;
    assign sel_ok = sel.table_sel == table_acl &&
                    sel.port_num >= port_first &&
                    sel.port_num <= port_last;
    // answer registered in the setup cycle so pready is high at access
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign word_idx = paddr[31:2];
    assign wr_data = access && pwrite && hit_data && sel_ok;
    assign hit_any = hit_ctrl || hit_off || hit_data;

    // each register takes its own word: byte address is four times the index
    // misaligned addresses hit nothing and answer with an error
    always_comb begin
        hit_ctrl = 1'b0;
        hit_off = 1'b0;
        hit_data = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            hit_ctrl = 1'b0;
        end else if (word_idx == {22'h0, table_port_select_off}) begin
            hit_ctrl = 1'b1;
        end else if (word_idx == {22'h0, byte_offset_off}) begin
            hit_off = 1'b1;
        end else if (word_idx == {22'h0, byte_data_off}) begin
            hit_data = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < num_ports; g++) begin : g_port
            acl_ip_match_entry u_entry (
                .mclk(mclk),
                .rst_b(rst_b),
                .wr_en(wr_data && sel.port_num == 4'(g + 1)),
                .wr_byte(sel.entry_byte),
                .wr_data(pwdata[7:0]),
                .ip_match_value(ip_match_next[g*16 +: 16])
            );

            // a write aimed at another port must leave this one alone
            iso_a: assert property (@(posedge mclk) disable iff (!rst_b)
                wr_data && sel.port_num != 4'(g + 1)
                |=> $stable(ip_match_next[g*16 +: 16]))
                else $error("write reached the wrong port");
        end
    endgenerate

    // selected entry byte; unimplemented bytes read zero
    always_comb begin
        entry_rd = 8'h00;
        for (int i = 0; i < num_ports; i++) begin
            if (sel.port_num == 4'(i + 1)) begin
                if (sel.entry_byte == rule_entry_byte_two) begin
                    entry_rd = ip_match_next[i*16+8 +: 8];
                end else if (sel.entry_byte == rule_entry_byte_three) begin
                    entry_rd = ip_match_next[i*16 +: 8];
                end
            end
        end
        if (!sel_ok) begin
            entry_rd = 8'h00;
        end
    end

    always_comb begin
        rd_next = 32'h00000000;
        err_next = 1'b0;
        if (hit_ctrl) begin
            rd_next = {24'h000000, ctrl_reg};
        end else if (hit_off) begin
            rd_next = {24'h000000, offset_reg};
        end else if (hit_data) begin
            rd_next = {24'h000000, entry_rd};
        end else begin
            err_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= ctrl_reset;
        end else if (access && pwrite && hit_ctrl) begin
            ctrl_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            offset_reg <= offset_reset;
        end else if (access && pwrite && hit_off) begin
            offset_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata_reg <= pwrite ? 32'h00000000 : rd_next;
                pslverr_reg <= err_next;
            end else begin
                prdata_reg <= 32'h00000000;
                pslverr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ip_match_reg <= '0;
        end else begin
            ip_match_reg <= ip_match_next;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign ip_match_value = ip_match_reg;

    // steps shared by the checks below
    sequence data_write_s;
        access && pready && pwrite && hit_data;
    endsequence

    sequence data_read_s;
        setup && !pwrite && hit_data && sel_ok;
    endsequence

    sequence ctrl_write_s;
        access && pready && pwrite && hit_ctrl;
    endsequence

    sequence off_write_s;
        access && pready && pwrite && hit_off;
    endsequence

    // bus timing
    ready_one_a: assert property (@(posedge mclk) disable iff (!rst_b)
        setup |=> pready)
        else $error("pready not one cycle after setup");

    ready_access_a: assert property (@(posedge mclk) disable iff (!rst_b)
        pready |-> $past(setup))
        else $error("pready without setup");

    ready_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    // entry bytes; the output lags the store by one cycle
    wr_hi_a: assert property (@(posedge mclk) disable iff (!rst_b)
        data_write_s and sel_ok and sel.entry_byte == rule_entry_byte_two
        |=> ##1 ip_match_value[(sel.port_num-1)*16+8 +: 8] ==
        $past(pwdata[7:0], 2))
        else $error("ip high byte not stored");

    wr_mid_a: assert property (@(posedge mclk) disable iff (!rst_b)
        data_write_s and sel_ok and sel.entry_byte == rule_entry_byte_three
        |=> ##1 ip_match_value[(sel.port_num-1)*16 +: 8] ==
        $past(pwdata[7:0], 2))
        else $error("ip mid byte not stored");

    rd_hi_a: assert property (@(posedge mclk) disable iff (!rst_b)
        data_read_s and sel.entry_byte == rule_entry_byte_two
        |=> prdata[7:0] == ip_match_value[(sel.port_num-1)*16+8 +: 8])
        else $error("ip high byte read mismatch");

    rd_mid_a: assert property (@(posedge mclk) disable iff (!rst_b)
        data_read_s and sel.entry_byte == rule_entry_byte_three
        |=> prdata[7:0] == ip_match_value[(sel.port_num-1)*16 +: 8])
        else $error("ip mid byte read mismatch");

    rd_odd_a: assert property (@(posedge mclk) disable iff (!rst_b)
        data_read_s and sel.entry_byte != rule_entry_byte_two &&
        sel.entry_byte != rule_entry_byte_three |=> prdata == 32'h00000000)
        else $error("unused entry byte read not zero");

    // control and offset bytes
    rd_ctrl_a: assert property (@(posedge mclk) disable iff (!rst_b)
        setup && !pwrite && hit_ctrl |=> prdata[7:0] == ctrl_reg)
        else $error("control byte read mismatch");

    rd_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        setup && !pwrite && hit_off |=> prdata[7:0] == offset_reg)
        else $error("offset byte read mismatch");

    ctrl_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ctrl_write_s |=> ctrl_reg == $past(pwdata[7:0]))
        else $error("control byte not stored");

    off_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
        off_write_s |=> offset_reg == $past(pwdata[7:0]))
        else $error("offset byte not stored");

    ctrl_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !(access && pwrite && hit_ctrl) |=> $stable(ctrl_reg))
        else $error("control byte changed without a write");

    off_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !(access && pwrite && hit_off) |=> $stable(offset_reg))
        else $error("offset byte changed without a write");

    // refused accesses
    bad_table_a: assert property (@(posedge mclk) disable iff (!rst_b)
        setup && !pwrite && hit_data && !sel_ok |=> prdata == 32'h00000000)
        else $error("data read not zero for foreign table or port");

    bad_wr_a: assert property (@(posedge mclk) disable iff (!rst_b)
        access && pwrite && hit_data && !sel_ok |=> $stable(ip_match_next))
        else $error("refused data write changed an entry");

    odd_byte_a: assert property (@(posedge mclk) disable iff (!rst_b)
        access && pwrite && hit_data && sel_ok &&
        sel.entry_byte != rule_entry_byte_two &&
        sel.entry_byte != rule_entry_byte_three |=> $stable(ip_match_next))
        else $error("write to an unused entry byte changed an entry");

    unmapped_a: assert property (@(posedge mclk) disable iff (!rst_b)
        setup && !hit_any |=> pslverr && pready)
        else $error("unmapped access not flagged");

    mapped_a: assert property (@(posedge mclk) disable iff (!rst_b)
        setup && hit_any |=> !pslverr)
        else $error("mapped access flagged as error");

    unmap_wr_a: assert property (@(posedge mclk) disable iff (!rst_b)
        access && pwrite && !hit_any |=> $stable(ctrl_reg) &&
        $stable(offset_reg) && $stable(ip_match_next))
        else $error("unmapped write changed state");

    // outputs during and between transfers
    rd_upper_a: assert property (@(posedge mclk) disable iff (!rst_b)
        pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    idle_out_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !pready |-> prdata == 32'h00000000 && !pslverr)
        else $error("read data or error outside access");

    ip_follow_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ip_match_value == $past(ip_match_next))
        else $error("ip output does not follow stored bytes");
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the rule indirect access register path
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import acl_pkg::*;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic er;
    logic [num_ports*16-1:0] ip_match_value, exp_ip;
    int fails, compares;

    acl_rule_indirect_access i_acl_rule_indirect_access (.mclk(mclk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ip_match_value(ip_match_value));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic complete_run();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // bounded wait on pready; the slave sets the pace, not the bench
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {22'h0, a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            complete_run();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic sel(input logic [2:0] t, input logic [3:0] p,
                       input logic [7:0] o);
        apb(1'b1, table_port_select_off, {t, 1'b0, p});
        apb(1'b1, byte_offset_off, o);
    endtask

    // settled output lags the stored byte by a cycle
    task automatic chk_ip();
        repeat (2) @(posedge mclk);
        chk(ip_match_value, exp_ip);
    endtask

    task automatic test_reset();
        chk(ip_match_value, 80'h0);
        apb(1'b0, table_port_select_off, 8'h00);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_ports();
        for (int p = 1; p <= num_ports; p++) begin
            sel(table_acl, p[3:0], rule_entry_byte_two);
            apb(1'b1, byte_data_off, 8'ha0 + p[7:0]);
            sel(table_acl, p[3:0], rule_entry_byte_three);
            apb(1'b1, byte_data_off, 8'h50 + p[7:0]);
            exp_ip[(p-1)*16 +: 16] = {8'ha0 + p[7:0], 8'h50 + p[7:0]};
        end
        for (int p = 1; p <= num_ports; p++) begin
            sel(table_acl, p[3:0], rule_entry_byte_two);
            apb(1'b0, byte_data_off, 8'h00);
            chk(rd, {24'h0, 8'ha0 + p[7:0]});
            apb(1'b0, byte_offset_off, 8'h00);
            chk(rd, {24'h0, rule_entry_byte_two});
            sel(table_acl, p[3:0], rule_entry_byte_three);
            apb(1'b0, byte_data_off, 8'h00);
            chk(rd, {24'h0, 8'h50 + p[7:0]});
        end
        chk_ip();
        $display("test ports done");
    endtask

    // wrong table, ports out of range, a byte outside the ip field
    task automatic test_refused();
        logic [2:0] tb_t [4] = '{3'h3, table_acl, table_acl, table_acl};
        logic [3:0] tb_p [4] = '{4'h1, 4'h0, 4'h6, 4'h1};
        logic [7:0] tb_o [4] = '{8'h02, 8'h02, 8'h02, 8'h04};
        for (int i = 0; i < 4; i++) begin
            sel(tb_t[i], tb_p[i], tb_o[i]);
            apb(1'b1, byte_data_off, 8'hff);
            apb(1'b0, byte_data_off, 8'h00);
            chk(rd, 32'h0);
            chk({79'h0, er}, 80'h0);
        end
        chk_ip();
        $display("test refused done");
    endtask

    task automatic test_unmapped();
        apb(1'b1, 8'h10, 8'h5a);
        chk({79'h0, er}, 80'h1);
        apb(1'b0, 8'h10, 8'h00);
        chk({47'h0, er, rd}, {47'h0, 1'b1, 32'h0});
        chk_ip();
        $display("test unmapped done");
    endtask

    initial begin
        fails = 0;
        compares = 0;
        exp_ip = '0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        test_reset();
        test_ports();
        test_refused();
        test_unmapped();
        complete_run();
    end
endmodule
`default_nettype wire
